// ==== src/dcffs_defines.vh ====
// Constants for the dual-clock FIFO flag block
`ifndef DCFFS_DEFINES_VH
`define DCFFS_DEFINES_VH

// ============================================================
// Register map
`define DCFFS_ADDR_CTRL     4'h0
`define DCFFS_ADDR_STAT     4'h4
`define DCFFS_ADDR_FILL     4'h8
`define DCFFS_CTRL_EN_BIT   0
`define DCFFS_CTRL_RST      1'b1
`define DCFFS_STAT_OFS_LSB  8
`define DCFFS_FILL_IB_LSB   16

// ============================================================
// Almost-flag offsets selected at reset release
`define DCFFS_OFS_HH        5'h10
`define DCFFS_OFS_HL        5'h0c
`define DCFFS_OFS_LH        5'h08
`define DCFFS_OFS_LL        5'h04

// ============================================================
// Narrow-port packing
`define DCFFS_BYTE_W        9
`define DCFFS_HALF_W        18
`define DCFFS_PH_WORD_LAST  2'h1
`define DCFFS_PH_BYTE_LAST  2'h3
`define DCFFS_PH_FIRST      2'h0

`endif

// ==== src/dcffs_top.v ====
// Flag and enable logic of two dual-port-clock long-word queues
// Function
// - Rx long-word write needs write enable high and one size select low.
// - Every flag passes two stages clocked by the port that observes it.
// - Empty flags live in the reader domain, full flags in the writer domain.
// - Reads ignored while empty flag low; allowed reads load the output register.
// - Tx empty flag falls as the last byte or word of final long word leaves.
// - Read pointer advances per long word loaded; comparator sees empty, +1, +2.
// - After a write into empty queue, empty flag rises on second reader edge.
// - A reader edge too close after the write defers to the next edge.
// - Writes ignored while full flag low; high full flag means space exists.
// - Write pointer advances per long word; comparator sees full, -1, -2.
// - After a read frees a full queue, full flag rises on second writer edge.
// - A writer edge too close after the read defers to the next edge.
// - Almost-empty low at X or fewer long words, high at X+1 or more.
// - Almost-empty rises on second reader edge after fill reaches X+1.
// - Almost-full comparator in writer domain, threshold from shared offset X.
// - Flags track fill up to 64: empty at 0, full at 64, almost-full from 64-X.
// - Almost-full low at 64-X or more, rises on second writer edge after read.
// - Offset loaded at reset release: HH 16, HL 12, LH 8, LL 4.
// - Reset clears pointers, flags low, almost-full high; full rises after two edges.
`timescale 1ns/100ps
`default_nettype none
`include "dcffs_defines.vh"

module dcffs_top #(
    parameter AW = 6
) (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire [3:0]  bus_addr,
    input  wire [31:0] bus_wdata,
    input  wire        bus_wr,
    input  wire        bus_rd,
    output reg  [31:0] bus_rdata,
    input  wire        wide_port_clock,
    input  wire        wide_write_en,
    input  wire        wide_read_en,
    input  wire [35:0] wide_data_in,
    output reg  [35:0] wide_data_out,
    input  wire        tx_port_clock,
    input  wire        tx_port_read_enable,
    output reg  [17:0] tx_port_data,
    input  wire        rx_port_clock,
    input  wire        rx_port_write_enable,
    input  wire [17:0] rx_port_data,
    input  wire        size_select_hi,
    input  wire        size_select_lo,
    input  wire        offset_select_hi,
    input  wire        offset_select_lo,
    output reg         wide_side_empty_n,
    output reg         wide_side_almost_empty_n,
    output reg         wide_side_full_n,
    output reg         wide_side_almost_full_n,
    output reg         tx_side_empty_n,
    output reg         tx_side_almost_empty_n,
    output reg         rx_side_full_n,
    output reg         rx_side_almost_full_n
);

    localparam PW = 65;
    localparam DEPTH = 1 << AW;
    localparam [AW:0] DEPTH_P = {1'b1, {AW{1'b0}}};

    // ============================================================
    // Decoding helpers
    function size_word;
        input lo;
        input hi;
        begin
            size_word = ~lo & hi;
        end
    endfunction

    function [1:0] last_phase;
        input word;
        begin
            last_phase = word ? `DCFFS_PH_WORD_LAST : `DCFFS_PH_BYTE_LAST;
        end
    endfunction

    function [17:0] part_of;
        input [35:0] w;
        input [1:0]  idx;
        input        word;
        begin
            if (word) begin
                part_of = idx[0] ? w[35:18] : w[17:0];
            end else begin
                case (idx)
                    2'h0:    part_of = {9'h000, w[8:0]};
                    2'h1:    part_of = {9'h000, w[17:9]};
                    2'h2:    part_of = {9'h000, w[26:18]};
                    default: part_of = {9'h000, w[35:27]};
                endcase
            end
        end
    endfunction

    // ============================================================
    // Pin synchronisers: port clocks are sampled as plain inputs, so
    // every pin except clk_sys, rst_b and the register bus, data included, sees the same two-stage delay
    wire [PW-1:0] pin_vec = {wide_port_clock, wide_write_en, wide_read_en, wide_data_in,
                             tx_port_clock, tx_port_read_enable, rx_port_clock,
                             rx_port_write_enable, rx_port_data, size_select_hi,
                             size_select_lo, offset_select_hi, offset_select_lo};
    reg  [PW-1:0] pin_s1_r;
    reg  [PW-1:0] pin_s2_r;

    always @(posedge clk_sys) begin
        pin_s1_r <= pin_vec;
        pin_s2_r <= pin_s1_r;
    end

    wire        wa_clk = pin_s2_r[64];
    wire        wa_wr  = pin_s2_r[63];
    wire        wa_rd  = pin_s2_r[62];
    wire [35:0] wa_dat = pin_s2_r[61:26];
    wire        tb_clk = pin_s2_r[25];
    wire        tb_ren = pin_s2_r[24];
    wire        rc_clk = pin_s2_r[23];
    wire        rc_wen = pin_s2_r[22];
    wire [17:0] rc_dat = pin_s2_r[21:4];
    wire        siz_hi = pin_s2_r[3];
    wire        siz_lo = pin_s2_r[2];
    wire        fs_hi  = pin_s2_r[1];
    wire        fs_lo  = pin_s2_r[0];

    reg wa_prev_r;
    reg tb_prev_r;
    reg rc_prev_r;
    wire wa_edge = wa_clk & ~wa_prev_r;
    wire tb_edge = tb_clk & ~tb_prev_r;
    wire rc_edge = rc_clk & ~rc_prev_r;

    // Reserved size codes disable both narrow ports
    wire       size_ok = siz_lo ^ siz_hi;
    wire       word_md = size_word(siz_lo, siz_hi);
    wire [1:0] ph_last = last_phase(word_md);

    // ============================================================
    // Control, offset and register bus
    reg       ctrl_en_r;
    reg       rst_q_r;
    reg [4:0] offset_r;

    // ============================================================
    // Queue state
    reg [35:0] ob_mem [0:DEPTH-1];
    reg [35:0] ib_mem [0:DEPTH-1];
    reg [AW:0] ob_wp_r;
    reg [AW:0] ob_rp_r;
    reg [AW:0] ob_ws_r;
    reg [AW:0] ob_rs_r;
    reg        ob_rdy_r;
    reg [1:0]  ob_ph_r;
    reg [35:0] ob_hold_r;
    reg [AW:0] ib_wp_r;
    reg [AW:0] ib_rp_r;
    reg [AW:0] ib_ws_r;
    reg [AW:0] ib_rs_r;
    reg        ib_rdy_r;
    reg [1:0]  ib_ph_r;
    reg [35:0] ib_asm_r;

    wire [AW:0] x_ext = {{(AW-4){1'b0}}, offset_r};

    // Accepted operations, gated by the registered flags
    wire ob_wr = wa_edge & wa_wr & ctrl_en_r & wide_side_full_n;
    wire ib_rd = wa_edge & wa_rd & ctrl_en_r & wide_side_empty_n;
    wire tb_rd = tb_edge & tb_ren & size_ok & tx_side_empty_n;
    wire rx_wr = rc_edge & rc_wen & size_ok & rx_side_full_n;

    wire ob_load = tb_rd & (ob_ph_r == `DCFFS_PH_FIRST);
    wire ib_last = rx_wr & (ib_ph_r == ph_last);

    wire [AW:0] ob_wp_nxt = ob_wp_r + {{AW{1'b0}}, ob_wr};
    wire [AW:0] ob_rp_nxt = ob_rp_r + {{AW{1'b0}}, ob_load};
    wire [AW:0] ib_wp_nxt = ib_wp_r + {{AW{1'b0}}, ib_last};
    wire [AW:0] ib_rp_nxt = ib_rp_r + {{AW{1'b0}}, ib_rd};

    wire [1:0] ob_ph_nxt = !tb_rd ? ob_ph_r :
                           (ob_ph_r == ph_last) ? `DCFFS_PH_FIRST : ob_ph_r + 2'h1;
    wire [35:0] ob_src  = ob_load ? ob_mem[ob_rp_r[AW-1:0]] : ob_hold_r;
    wire [17:0] tx_part = part_of(ob_src, ob_ph_r, word_md);

    // Fill as seen by each side: own pointer current, far pointer one stage old
    wire [AW:0] ob_fill_rd = ob_ws_r - ob_rp_nxt;
    wire [AW:0] ob_fill_wr = ob_wp_nxt - ob_rs_r;
    wire [AW:0] ib_fill_rd = ib_ws_r - ib_rp_nxt;
    wire [AW:0] ib_fill_wr = ib_wp_nxt - ib_rs_r;

    // Rx long word with the incoming part merged in
    reg [35:0] ib_word;
    always @* begin
        ib_word = ib_asm_r;
        if (word_md) begin
            if (ib_ph_r[0]) begin
                ib_word[35:18] = rc_dat;
            end else begin
                ib_word[17:0] = rc_dat;
            end
        end else begin
            ib_word[ib_ph_r * `DCFFS_BYTE_W +: `DCFFS_BYTE_W] = rc_dat[8:0];
        end
    end

    // ============================================================
    // Memories: no reset, contents are undefined until written
    always @(posedge clk_sys) begin
        if (ob_wr) begin
            ob_mem[ob_wp_r[AW-1:0]] <= wa_dat;
        end
        if (ib_last) begin
            ib_mem[ib_wp_r[AW-1:0]] <= ib_word;
        end
    end

    // ============================================================
    // Control state
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            // Edge registers follow the pins through reset, so release makes no false rise
            wa_prev_r <= wa_clk;
            tb_prev_r <= tb_clk;
            rc_prev_r <= rc_clk;
            ctrl_en_r <= `DCFFS_CTRL_RST;
            rst_q_r   <= 1'b0;
            offset_r  <= `DCFFS_OFS_LL;
            bus_rdata <= 32'h00000000;
        end else begin
            wa_prev_r <= wa_clk;
            tb_prev_r <= tb_clk;
            rc_prev_r <= rc_clk;
            rst_q_r   <= 1'b1;
            // Straps caught on the first cycle after release
            if (!rst_q_r) begin
                case ({fs_hi, fs_lo})
                    2'b11:   offset_r <= `DCFFS_OFS_HH;
                    2'b10:   offset_r <= `DCFFS_OFS_HL;
                    2'b01:   offset_r <= `DCFFS_OFS_LH;
                    default: offset_r <= `DCFFS_OFS_LL;
                endcase
            end
            if (bus_wr && bus_addr == `DCFFS_ADDR_CTRL) begin
                ctrl_en_r <= bus_wdata[`DCFFS_CTRL_EN_BIT];
            end
            bus_rdata <= 32'h00000000;
            if (bus_rd) begin
                case (bus_addr)
                    `DCFFS_ADDR_CTRL: begin
                        bus_rdata[`DCFFS_CTRL_EN_BIT] <= ctrl_en_r;
                    end
                    `DCFFS_ADDR_STAT: begin
                        bus_rdata[7:0] <= {rx_side_almost_full_n, rx_side_full_n,
                                           tx_side_almost_empty_n, tx_side_empty_n,
                                           wide_side_almost_full_n, wide_side_full_n,
                                           wide_side_almost_empty_n, wide_side_empty_n};
                        bus_rdata[`DCFFS_STAT_OFS_LSB +: 5] <= offset_r;
                    end
                    `DCFFS_ADDR_FILL: begin
                        bus_rdata[AW:0] <= ob_wp_r - ob_rp_r;
                        bus_rdata[`DCFFS_FILL_IB_LSB +: AW+1] <= ib_wp_r - ib_rp_r;
                    end
                    default: begin
                        bus_rdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Outbound queue: wide port writes, tx port reads
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            ob_wp_r                 <= {(AW+1){1'b0}};
            ob_rp_r                 <= {(AW+1){1'b0}};
            ob_ws_r                 <= {(AW+1){1'b0}};
            ob_rs_r                 <= {(AW+1){1'b0}};
            ob_rdy_r                <= 1'b0;
            ob_ph_r                 <= `DCFFS_PH_FIRST;
            ob_hold_r               <= 36'h000000000;
            tx_port_data            <= 18'h00000;
            tx_side_empty_n         <= 1'b0;
            tx_side_almost_empty_n  <= 1'b0;
            wide_side_full_n        <= 1'b0;
            wide_side_almost_full_n <= 1'b1;
        end else begin
            ob_wp_r <= ob_wp_nxt;
            ob_rp_r <= ob_rp_nxt;
            ob_ph_r <= ob_ph_nxt;
            if (ob_load) begin
                ob_hold_r <= ob_mem[ob_rp_r[AW-1:0]];
            end
            // Byte mode leaves the upper half static to save toggling
            if (tb_rd) begin
                if (word_md) begin
                    tx_port_data <= tx_part;
                end else begin
                    tx_port_data[8:0] <= tx_part[8:0];
                end
            end
            // Reader-side flags: stage one copies the write pointer, stage two is the flag
            if (tb_edge) begin
                ob_ws_r <= ob_wp_r;
                tx_side_empty_n <= (ob_fill_rd != {(AW+1){1'b0}}) |
                                   (ob_ph_nxt != `DCFFS_PH_FIRST);
                tx_side_almost_empty_n <= (ob_fill_rd > x_ext);
            end
            // Writer-side flags, same two stages on the wide clock
            if (wa_edge) begin
                ob_rs_r  <= ob_rp_r;
                ob_rdy_r <= 1'b1;
                wide_side_full_n <= ob_rdy_r & (ob_fill_wr != DEPTH_P);
                wide_side_almost_full_n <= (ob_fill_wr < DEPTH_P - x_ext);
            end
        end
    end

    // ============================================================
    // Inbound queue: rx port writes, wide port reads
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            ib_wp_r                  <= {(AW+1){1'b0}};
            ib_rp_r                  <= {(AW+1){1'b0}};
            ib_ws_r                  <= {(AW+1){1'b0}};
            ib_rs_r                  <= {(AW+1){1'b0}};
            ib_rdy_r                 <= 1'b0;
            ib_ph_r                  <= `DCFFS_PH_FIRST;
            ib_asm_r                 <= 36'h000000000;
            wide_data_out            <= 36'h000000000;
            wide_side_empty_n        <= 1'b0;
            wide_side_almost_empty_n <= 1'b0;
            rx_side_full_n           <= 1'b0;
            rx_side_almost_full_n    <= 1'b1;
        end else begin
            ib_wp_r <= ib_wp_nxt;
            ib_rp_r <= ib_rp_nxt;
            if (rx_wr) begin
                ib_asm_r <= ib_word;
                ib_ph_r  <= ib_last ? `DCFFS_PH_FIRST : ib_ph_r + 2'h1;
            end
            if (ib_rd) begin
                wide_data_out <= ib_mem[ib_rp_r[AW-1:0]];
            end
            if (wa_edge) begin
                ib_ws_r <= ib_wp_r;
                wide_side_empty_n <= (ib_fill_rd != {(AW+1){1'b0}});
                wide_side_almost_empty_n <= (ib_fill_rd > x_ext);
            end
            if (rc_edge) begin
                ib_rs_r  <= ib_rp_r;
                ib_rdy_r <= 1'b1;
                rx_side_full_n <= ib_rdy_r & (ib_fill_wr != DEPTH_P);
                rx_side_almost_full_n <= (ib_fill_wr < DEPTH_P - x_ext);
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb/dcffs_pclk.sv ====
// Port clock model for one far-side bus master
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Free-running port clock with a one-cycle pulse after each fall
module dcffs_pclk #(
    parameter int HALF = 4
) (
    input  wire logic clk_sys,
    output var  logic pin,
    output var  logic fall
);
    logic [3:0] cnt;

    initial begin
        pin = 1'b0;
        fall = 1'b0;
        cnt = 4'h0;
    end

    // Half period of at least 4 system cycles keeps the pin sampler happy
    always @(posedge clk_sys) begin
        fall <= 1'b0;
        if (cnt == 4'(HALF - 1)) begin
            cnt <= 4'h0;
            pin <= !pin;
            fall <= pin;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

`default_nettype wire

// ==== tb/dcffs_top_asserts.sv ====
// Concurrent checks on the flag outputs of the queue flag block
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Checker
module dcffs_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wide_port_clock,
    input wire logic tx_port_clock,
    input wire logic rx_port_clock,
    input wire logic wide_side_empty_n,
    input wire logic wide_side_almost_empty_n,
    input wire logic wide_side_full_n,
    input wire logic wide_side_almost_full_n,
    input wire logic tx_side_empty_n,
    input wire logic tx_side_almost_empty_n,
    input wire logic rx_side_full_n,
    input wire logic rx_side_almost_full_n
);
    logic [2:0] p1;
    logic [2:0] p2;
    logic [2:0] p3;
    logic [2:0] r;
    logic [2:0] sc [3];
    logic [1:0] rc [3];

    // Rise seen after two stages and an edge register, like the design's own pin sampler
    assign r = p2 & ~p3;

    always_ff @(posedge clk_sys) begin
        p1 <= {rx_port_clock, tx_port_clock, wide_port_clock};
        p2 <= p1;
        p3 <= p2;
        for (int i = 0; i < 3; i++) begin
            if (!rst_b) begin
                sc[i] <= 3'h7;
                rc[i] <= 2'h0;
            end else if (r[i]) begin
                sc[i] <= 3'h0;
                rc[i] <= rc[i] + {1'b0, rc[i] != 2'h3};
            end else if (sc[i] != 3'h7) begin
                sc[i] <= sc[i] + 3'h1;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_reset_flags: assert property (disable iff (1'b0) !rst_b |=>
        !wide_side_empty_n && !wide_side_full_n && wide_side_almost_full_n
        && !tx_side_empty_n && !rx_side_full_n && rx_side_almost_full_n)
        else $error("flags wrong during reset");
    a_wide_flag_dom: assert property ($changed({wide_side_empty_n, wide_side_almost_empty_n,
        wide_side_full_n, wide_side_almost_full_n}) |-> sc[0] <= 3'h3)
        else $error("wide flag moved away from a wide clock rise");
    a_tx_flag_dom: assert property ($changed({tx_side_empty_n, tx_side_almost_empty_n})
        |-> sc[1] <= 3'h3) else $error("tx flag moved away from a tx clock rise");
    a_rx_flag_dom: assert property ($changed({rx_side_full_n, rx_side_almost_full_n})
        |-> sc[2] <= 3'h3) else $error("rx flag moved away from an rx clock rise");
    a_wfull_two_rises: assert property (wide_side_full_n |-> rc[0][1])
        else $error("wide full flag high before two wide rises");
    a_rfull_two_rises: assert property (rx_side_full_n |-> rc[2][1])
        else $error("rx full flag high before two rx rises");
    a_ae_implies_e: assert property (tx_side_almost_empty_n |-> tx_side_empty_n)
        else $error("tx almost-empty high while empty");
    a_full_after_af: assert property ($fell(wide_side_full_n) |-> !wide_side_almost_full_n)
        else $error("wide full without almost-full");

    c_tx_data: cover property ($rose(tx_side_empty_n));
    c_wide_data: cover property ($rose(wide_side_empty_n));
    c_out_full: cover property ($fell(wide_side_full_n));
endmodule

bind dcffs_top dcffs_chk u_dcffs_chk (.*);

`default_nettype wire

// ==== tb/dcffs_top_tb.sv ====
// Self-checking bench for the queue flag block
`timescale 1ns/100ps
`default_nettype none

module dcffs_top_tb;
    localparam logic [35:0] W1 = 36'h987654321;
    logic        clk_sys, rst_b, bus_wr, bus_rd, wide_write_en, wide_read_en;
    logic        tx_port_read_enable, rx_port_write_enable;
    logic        size_select_hi, size_select_lo, offset_select_hi, offset_select_lo;
    logic [3:0]  bus_addr;
    logic [31:0] bus_wdata, bus_rdata, d;
    logic [35:0] wide_data_in, wide_data_out;
    logic [17:0] tx_port_data, rx_port_data;
    wire  [7:0]  flags;
    wire  [2:0]  pin, fall;
    logic [6:0]  rows [4];
    int          n_mismatch, num_checks;

    dcffs_pclk #(.HALF(4)) u_dcffs_pclk_w (.clk_sys(clk_sys), .pin(pin[0]), .fall(fall[0]));
    dcffs_pclk #(.HALF(5)) u_dcffs_pclk_t (.clk_sys(clk_sys), .pin(pin[1]), .fall(fall[1]));
    dcffs_pclk #(.HALF(6)) u_dcffs_pclk_r (.clk_sys(clk_sys), .pin(pin[2]), .fall(fall[2]));

    dcffs_top u_dcffs_top (.clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .wide_port_clock(pin[0]), .wide_write_en(wide_write_en), .wide_read_en(wide_read_en),
        .wide_data_in(wide_data_in), .wide_data_out(wide_data_out), .tx_port_clock(pin[1]),
        .tx_port_read_enable(tx_port_read_enable), .tx_port_data(tx_port_data),
        .rx_port_clock(pin[2]), .rx_port_write_enable(rx_port_write_enable),
        .rx_port_data(rx_port_data), .size_select_hi(size_select_hi),
        .size_select_lo(size_select_lo), .offset_select_hi(offset_select_hi),
        .offset_select_lo(offset_select_lo), .wide_side_empty_n(flags[0]),
        .wide_side_almost_empty_n(flags[1]), .wide_side_full_n(flags[2]),
        .wide_side_almost_full_n(flags[3]), .tx_side_empty_n(flags[4]),
        .tx_side_almost_empty_n(flags[5]), .rx_side_full_n(flags[6]),
        .rx_side_almost_full_n(flags[7]));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ============================================================
    // Tasks
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Enables change two cycles after a port clock fall, so they stand well around the rise
    task automatic wf(input int p);
        int i;
        for (i = 0; i < 40 && !fall[p]; i++) @(posedge clk_sys);
        if (i == 40) begin
            n_mismatch++;
            wrap_up();
        end
        @(posedge clk_sys);
    endtask

    task automatic idle(input int p, input int n);
        repeat (n) wf(p);
    endtask

    // Data lines are inverted after release so a stale value never looks valid
    task automatic wop(input logic w, input logic r, input logic [35:0] dv);
        wf(0);
        wide_write_en <= w;
        wide_read_en <= r;
        wide_data_in <= dv;
        wf(0);
        wide_write_en <= 1'b0;
        wide_read_en <= 1'b0;
        wide_data_in <= ~dv;
    endtask

    task automatic txr();
        wf(1);
        tx_port_read_enable <= 1'b1;
        wf(1);
        tx_port_read_enable <= 1'b0;
    endtask

    task automatic rxw(input logic [17:0] dv);
        wf(2);
        rx_port_write_enable <= 1'b1;
        rx_port_data <= dv;
        wf(2);
        rx_port_write_enable <= 1'b0;
        rx_port_data <= ~dv;
    endtask

    task automatic brd(input logic [3:0] a);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(posedge clk_sys);
        d = bus_rdata;
    endtask

    task automatic bwr(input logic [3:0] a, input logic [31:0] v);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        {rst_b, bus_wr, bus_rd, wide_write_en, wide_read_en} = 5'h0;
        {tx_port_read_enable, rx_port_write_enable, offset_select_hi, offset_select_lo} = 4'h0;
        size_select_hi = 1'b1;
        size_select_lo = 1'b0;
        {bus_addr, bus_wdata, wide_data_in, rx_port_data} = 90'h0;
        rows = '{7'h70, 7'h4c, 7'h28, 7'h04};
        @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            rst_b <= 1'b0;
            offset_select_hi <= rows[k][6];
            offset_select_lo <= rows[k][5];
            repeat (12) @(posedge clk_sys);
            chk("flags_rst", flags, 8'h88);
            rst_b <= 1'b1;
            idle(0, 3);
            idle(2, 3);
            brd(4'h4);
            chk("stat", d[12:0], {rows[k][4:0], 8'hcc});
        end
        brd(4'hc);
        chk("unmapped", d, 0);
        bwr(4'h0, 32'h0);
        wop(1'b1, 1'b0, W1);
        brd(4'h8);
        chk("fill_off", d, 0);
        bwr(4'h0, 32'h1);
        // Word mode read of one long word in two parts
        wop(1'b1, 1'b0, W1);
        idle(1, 3);
        chk("tx_e", flags[5:4], 2'h1);
        txr();
        chk("tx_lo", tx_port_data, W1[17:0]);
        chk("tx_e1", flags[4], 1'b1);
        txr();
        chk("tx_hi", tx_port_data, W1[35:18]);
        chk("tx_e2", flags[4], 1'b0);
        txr();
        chk("tx_hold", tx_port_data, W1[35:18]);
        // Receive side, then reserved size select
        rxw(W1[17:0]);
        rxw(W1[35:18]);
        idle(0, 3);
        chk("wide_e", flags[0], 1'b1);
        wop(1'b0, 1'b1, 36'h0);
        chk("wide_out", wide_data_out, W1);
        size_select_lo <= 1'b1;
        rxw(W1[17:0]);
        rxw(W1[35:18]);
        size_select_lo <= 1'b0;
        brd(4'h8);
        chk("fill_rsv", d[22:16], 7'h0);
        // Fill the outbound queue past its depth with offset 4
        for (int k = 1; k <= 65; k++) begin
            wop(1'b1, 1'b0, 36'(k));
            if (k == 4 || k == 5) begin
                idle(1, 3);
                chk("tx_ae", flags[5], k == 5);
            end
            if (k == 59 || k == 60) begin
                idle(0, 3);
                chk("wide_af", flags[3], k == 59);
            end
        end
        idle(0, 3);
        chk("wide_full", flags[2], 1'b0);
        brd(4'h8);
        chk("fill_max", d[6:0], 7'h40);
        txr();
        chk("tx_first", tx_port_data, 18'h1);
        txr();
        idle(0, 3);
        chk("wide_free", flags[3:2], 2'h1);
        // Byte mode after a fresh reset: four parts per long word each way
        rst_b <= 1'b0;
        size_select_hi <= 1'b0;
        size_select_lo <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        idle(0, 3);
        idle(2, 3);
        for (int k = 0; k < 4; k++) begin
            rxw(18'(W1[k*9 +: 9]));
        end
        idle(0, 3);
        chk("wide_e_byte", flags[1:0], 2'h1);
        wop(1'b1, 1'b1, W1);
        chk("wide_byte", wide_data_out, W1);
        idle(1, 3);
        for (int k = 0; k < 4; k++) begin
            txr();
            chk("tx_byte", tx_port_data[8:0], W1[k*9 +: 9]);
            chk("tx_e_byte", flags[4], k != 3);
        end
        wrap_up();
    end
endmodule

`default_nettype wire
